// ---- pkg/lbx_pkg.sv ----
// package: opcodes, command layout, register map and constants
`default_nettype none
package lbx_pkg;

   // ----------------------------------------
   // operation codes
   // ----------------------------------------
   typedef enum logic [4:0] {
      OP_DISJUNCT_REGS        = 5'h00,
      OP_DISJUNCT_IMM         = 5'h01,
      OP_XDISJUNCT_REGS       = 5'h02,
      OP_INVERT_ALL_BITS      = 5'h03,
      OP_SET_MASK_BITS        = 5'h04,
      OP_CLEAR_MASK_BITS      = 5'h05,
      OP_ZERO_SIGN_CHECK      = 5'h06,
      OP_ZERO_REGISTER        = 5'h07,
      OP_SUBTRACT_ONE         = 5'h08,
      OP_REL_JUMP             = 5'h09,
      OP_REL_SUBROUTINE_CALL  = 5'h0a,
      OP_POINTER_JUMP         = 5'h0b,
      OP_POINTER_CALL         = 5'h0c,
      OP_EQUAL_SKIP           = 5'h0d,
      OP_IMM_COMPARE          = 5'h0e,
      OP_SKIP_REG_BIT_LOW     = 5'h0f,
      OP_SKIP_REG_BIT_HIGH    = 5'h10,
      OP_SKIP_IO_BIT_LOW      = 5'h11,
      OP_SKIP_IO_BIT_HIGH     = 5'h12,
      OP_BRANCH_FLAG_HIGH     = 5'h13,
      OP_BRANCH_FLAG_LOW      = 5'h14,
      OP_BRANCH_CARRY_HIGH    = 5'h15,
      OP_BRANCH_CARRY_LOW     = 5'h16
   } lbx_op_e;

   // ----------------------------------------
   // command word, low 28 bits of a write
   // ----------------------------------------
   typedef struct packed {
      logic        two_word;
      logic [11:0] k;
      logic [4:0]  rr;
      logic [4:0]  rd;
      lbx_op_e     op;
   } lbx_cmd_s;

   // ----------------------------------------
   // register map, byte addresses
   // ----------------------------------------
   localparam logic [7:0] A_CMD   = 8'h00;
   localparam logic [7:0] A_STAT  = 8'h04;
   localparam logic [7:0] A_PC    = 8'h08;
   localparam logic [7:0] A_PTR   = 8'h0c;
   localparam logic [7:0] A_RSEL  = 8'h10;
   localparam logic [7:0] A_RDATA = 8'h14;
   localparam logic [7:0] A_IOV   = 8'h18;
   localparam logic [7:0] A_LINK  = 8'h1c;

   // ----------------------------------------
   // flag positions, values, counts
   // ----------------------------------------
   localparam int F_C = 0;
   localparam int F_Z = 1;
   localparam int F_N = 2;
   localparam int F_V = 3;
   localparam int F_H = 5;
   localparam logic [7:0]  FLAGS_RST = 8'h00;
   localparam logic [15:0] PC_RST    = 16'h0000;
   localparam logic [7:0]  ALL_ONES  = 8'hff;
   localparam logic [7:0]  SIGN_MIN  = 8'h80;
   localparam logic [15:0] PC_STEP   = 16'h0001;
   localparam logic [15:0] SKIP_ONE  = 16'h0002;
   localparam logic [15:0] SKIP_TWO  = 16'h0003;
   localparam logic [1:0]  CYC_ONE   = 2'h1;
   localparam logic [1:0]  CYC_TWO   = 2'h2;
   localparam logic [1:0]  CYC_THREE = 2'h3;
   localparam logic [1:0]  RESP_OKAY = 2'h0;
   localparam logic [1:0]  RESP_ERR  = 2'h2;

endpackage
`default_nettype wire

// ---- logic/lbx_exec.sv ----
// logic and branch execution unit behind an axi4-lite slave
//
// Function
// RQ1: or with register or constant, flags
// RQ2: set or clear bits by mask
// RQ3: ones complement, sets carry
// RQ4: and register with itself, flags
// RQ5: xor register with itself clears it
// RQ6: decrement, carry kept, one cycle
// RQ7: relative jump two, call three cycles
// RQ8: pointer jump from pair, two cycles
// RQ9: pointer call from pair, three cycles
// RQ10: skip next when registers equal
// RQ11: compare with constant, flags only
// RQ12: skip on working register bit
// RQ13: skip on io register bit
// RQ14: branch on selected flag bit
// RQ15: branch on carry set or clear
// RQ16: counter in words, skips one or two
// RQ17: offsets signed, added to next address
`timescale 1ns/10ps
`default_nettype none
module lbx_exec (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready
);

   // ----------------------------------------
   // functions
   // ----------------------------------------
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a <= lbx_pkg::A_LINK) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] o,
                                           input logic [15:0] n,
                                           input logic [1:0]  s);
      merge16 = {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0]        regs      [32];
   logic [7:0]        next_regs [32];
   logic [7:0]        flags, next_flags;
   logic [15:0]       pc, next_pc;
   logic [15:0]       zptr, next_zptr;
   logic [15:0]       link, next_link;
   logic [7:0]        iov, next_iov;
   logic [4:0]        rsel, next_rsel;
   lbx_pkg::lbx_cmd_s cmd_q, next_cmd;
   logic [1:0]        cnt, next_cnt;
   logic [1:0]        last_cyc, next_last;
   logic              next_awready, next_wready, next_bvalid;
   logic              next_arready, next_rvalid;
   logic [1:0]        next_bresp, next_rresp;
   logic [31:0]       next_rdata, rmux;

   lbx_pkg::lbx_cmd_s c;
   logic              wr_fire, rd_fire, busy, go;
   logic [7:0]        a, b, imm, res;
   logic [8:0]        diff;
   logic [15:0]       rel12, rel7, tgt;
   logic              wb, fl, vf, skip;
   logic [1:0]        cyc;

   assign c       = lbx_pkg::lbx_cmd_s'(wdata[27:0]);
   assign wr_fire = awready & awvalid & wvalid;
   assign rd_fire = arready & arvalid;
   assign busy    = cnt != 2'h0;
   // a command arriving during a multi-cycle one is refused
   assign go      = ce & wr_fire & (awaddr == lbx_pkg::A_CMD) & !busy;
   assign a       = regs[c.rd];
   assign b       = regs[c.rr];
   assign imm     = c.k[7:0];
   // RQ17: sign extend offsets
   assign rel12   = {{4{c.k[11]}}, c.k};
   assign rel7    = {{9{c.k[6]}}, c.k[6:0]};

   // ----------------------------------------
   // execution
   // ----------------------------------------
   always_comb begin
      next_regs  = regs;
      next_flags = flags;
      next_pc    = pc;
      next_zptr  = zptr;
      next_link  = link;
      next_iov   = iov;
      next_rsel  = rsel;
      next_cmd   = cmd_q;
      next_last  = last_cyc;
      next_cnt   = busy ? cnt - 2'h1 : cnt;
      diff = {1'b0, a} - {1'b0, imm};
      res  = 8'h00;
      wb   = 1'b0;
      fl   = 1'b0;
      vf   = 1'b0;
      skip = 1'b0;
      cyc  = lbx_pkg::CYC_ONE;
      // RQ16: word counter, plain advance
      tgt  = pc + lbx_pkg::PC_STEP;
      if (wr_fire) begin
         if (awaddr == lbx_pkg::A_PC) begin
            next_pc = merge16(pc, wdata[15:0], wstrb[1:0]);
         end else if (awaddr == lbx_pkg::A_PTR) begin
            next_zptr = merge16(zptr, wdata[15:0], wstrb[1:0]);
         end else if (awaddr == lbx_pkg::A_RSEL && wstrb[0]) begin
            next_rsel = wdata[4:0];
         end else if (awaddr == lbx_pkg::A_RDATA && wstrb[0]) begin
            next_regs[rsel] = wdata[7:0];
         end else if (awaddr == lbx_pkg::A_IOV && wstrb[0]) begin
            next_iov = wdata[7:0];
         end
      end
      if (go) begin
         next_cmd = c;
         case (c.op)
            // RQ1: or write back
            lbx_pkg::OP_DISJUNCT_REGS: begin
               res = a | b;
               wb  = 1'b1;
               fl  = 1'b1;
            end
            lbx_pkg::OP_DISJUNCT_IMM, lbx_pkg::OP_SET_MASK_BITS: begin
               res = a | imm;
               wb  = 1'b1;
               fl  = 1'b1;
            end
            // RQ2: mask clear form
            lbx_pkg::OP_CLEAR_MASK_BITS: begin
               res = a & (lbx_pkg::ALL_ONES - imm);
               wb  = 1'b1;
               fl  = 1'b1;
            end
            // RQ5: xor clear
            lbx_pkg::OP_XDISJUNCT_REGS, lbx_pkg::OP_ZERO_REGISTER: begin
               res = (c.op == lbx_pkg::OP_ZERO_REGISTER) ? a ^ a : a ^ b;
               wb  = 1'b1;
               fl  = 1'b1;
            end
            // RQ3: complement sets carry
            lbx_pkg::OP_INVERT_ALL_BITS: begin
               res = lbx_pkg::ALL_ONES - a;
               wb  = 1'b1;
               fl  = 1'b1;
               next_flags[lbx_pkg::F_C] = 1'b1;
            end
            // RQ4: self and test
            lbx_pkg::OP_ZERO_SIGN_CHECK: begin
               res = a & a;
               wb  = 1'b1;
               fl  = 1'b1;
            end
            // RQ6: decrement keeps carry
            lbx_pkg::OP_SUBTRACT_ONE: begin
               res = a - 8'h01;
               wb  = 1'b1;
               fl  = 1'b1;
               vf  = a == lbx_pkg::SIGN_MIN;
            end
            // RQ11: compare, result dropped
            lbx_pkg::OP_IMM_COMPARE: begin
               res = diff[7:0];
               fl  = 1'b1;
               vf  = (a[7] & ~imm[7] & ~res[7]) | (~a[7] & imm[7] & res[7]);
               next_flags[lbx_pkg::F_C] = diff[8];
               next_flags[lbx_pkg::F_H] = (~a[3] & imm[3]) |
                                          (imm[3] & res[3]) |
                                          (res[3] & ~a[3]);
            end
            // RQ7: relative jump and call
            lbx_pkg::OP_REL_JUMP, lbx_pkg::OP_REL_SUBROUTINE_CALL: begin
               tgt = pc + lbx_pkg::PC_STEP + rel12;
               cyc = (c.op == lbx_pkg::OP_REL_JUMP) ? lbx_pkg::CYC_TWO
                                                  : lbx_pkg::CYC_THREE;
            end
            // RQ8: pointer jump
            lbx_pkg::OP_POINTER_JUMP: begin
               tgt = zptr;
               cyc = lbx_pkg::CYC_TWO;
            end
            // RQ9: pointer call
            lbx_pkg::OP_POINTER_CALL: begin
               tgt = zptr;
               cyc = lbx_pkg::CYC_THREE;
            end
            // RQ10: equality skip
            lbx_pkg::OP_EQUAL_SKIP:        skip = a == b;
            // RQ12: register bit skips
            lbx_pkg::OP_SKIP_REG_BIT_LOW:  skip = !b[c.k[2:0]];
            lbx_pkg::OP_SKIP_REG_BIT_HIGH: skip = b[c.k[2:0]];
            // RQ13: io bit skips
            lbx_pkg::OP_SKIP_IO_BIT_LOW:   skip = !iov[c.k[2:0]];
            lbx_pkg::OP_SKIP_IO_BIT_HIGH:  skip = iov[c.k[2:0]];
            // RQ14: selected flag branch
            lbx_pkg::OP_BRANCH_FLAG_HIGH, lbx_pkg::OP_BRANCH_FLAG_LOW: begin
               if (flags[c.rr[2:0]] ==
                   (c.op == lbx_pkg::OP_BRANCH_FLAG_HIGH)) begin
                  tgt = pc + lbx_pkg::PC_STEP + rel7;
                  cyc = lbx_pkg::CYC_TWO;
               end
            end
            // RQ15: carry branch
            lbx_pkg::OP_BRANCH_CARRY_HIGH, lbx_pkg::OP_BRANCH_CARRY_LOW: begin
               if (flags[lbx_pkg::F_C] ==
                   (c.op == lbx_pkg::OP_BRANCH_CARRY_HIGH)) begin
                  tgt = pc + lbx_pkg::PC_STEP + rel7;
                  cyc = lbx_pkg::CYC_TWO;
               end
            end
            default: cyc = lbx_pkg::CYC_ONE;
         endcase
         // RQ16: skip one or two words
         if (skip) begin
            tgt = pc + (c.two_word ? lbx_pkg::SKIP_TWO : lbx_pkg::SKIP_ONE);
            cyc = c.two_word ? lbx_pkg::CYC_THREE : lbx_pkg::CYC_TWO;
         end
         if (c.op == lbx_pkg::OP_REL_SUBROUTINE_CALL ||
             c.op == lbx_pkg::OP_POINTER_CALL) begin
            next_link = pc + lbx_pkg::PC_STEP;
         end
         if (wb) begin
            next_regs[c.rd] = res;
         end
         if (fl) begin
            next_flags[lbx_pkg::F_Z] = res == 8'h00;
            next_flags[lbx_pkg::F_N] = res[7];
            next_flags[lbx_pkg::F_V] = vf;
         end
         next_pc   = tgt;
         next_cnt  = cyc - 2'h1;
         next_last = cyc;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 32; i++) begin
            regs[i] <= 8'h00;
         end
         flags    <= lbx_pkg::FLAGS_RST;
         pc       <= lbx_pkg::PC_RST;
         zptr     <= lbx_pkg::PC_RST;
         link     <= lbx_pkg::PC_RST;
         iov      <= 8'h00;
         rsel     <= 5'h00;
         cmd_q    <= lbx_pkg::lbx_cmd_s'(28'h0);
         cnt      <= 2'h0;
         last_cyc <= 2'h0;
      end else if (ce) begin
         regs     <= next_regs;
         flags    <= next_flags;
         pc       <= next_pc;
         zptr     <= next_zptr;
         link     <= next_link;
         iov      <= next_iov;
         rsel     <= next_rsel;
         cmd_q    <= next_cmd;
         cnt      <= next_cnt;
         last_cyc <= next_last;
      end
   end

   // ----------------------------------------
   // axi4-lite slave
   // ----------------------------------------
   always_comb begin
      if (araddr == lbx_pkg::A_CMD) begin
         rmux = {4'h0, cmd_q};
      end else if (araddr == lbx_pkg::A_STAT) begin
         rmux = {21'h0, last_cyc, busy, flags};
      end else if (araddr == lbx_pkg::A_PC) begin
         rmux = {16'h0, pc};
      end else if (araddr == lbx_pkg::A_PTR) begin
         rmux = {16'h0, zptr};
      end else if (araddr == lbx_pkg::A_RSEL) begin
         rmux = {27'h0, rsel};
      end else if (araddr == lbx_pkg::A_RDATA) begin
         rmux = {24'h0, regs[rsel]};
      end else if (araddr == lbx_pkg::A_IOV) begin
         rmux = {24'h0, iov};
      end else if (araddr == lbx_pkg::A_LINK) begin
         rmux = {16'h0, link};
      end else begin
         rmux = 32'h0;
      end
   end

   always_comb begin
      // ready only with both channels offered, so they are taken together
      next_awready = !awready && !bvalid && awvalid && wvalid;
      next_wready  = next_awready;
      next_bvalid  = bvalid ? !bready : wr_fire;
      next_bresp   = bresp;
      if (wr_fire) begin
         next_bresp = (mapped(awaddr) &&
                       !(awaddr == lbx_pkg::A_CMD && busy))
                      ? lbx_pkg::RESP_OKAY : lbx_pkg::RESP_ERR;
      end
      next_arready = !arready && !rvalid && arvalid;
      next_rvalid  = rvalid ? !rready : rd_fire;
      next_rdata   = rdata;
      next_rresp   = rresp;
      if (rd_fire) begin
         next_rdata = rmux;
         next_rresp = mapped(araddr) ? lbx_pkg::RESP_OKAY
                                     : lbx_pkg::RESP_ERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= lbx_pkg::RESP_OKAY;
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0;
         rresp   <= lbx_pkg::RESP_OKAY;
      end else if (ce) begin
         awready <= next_awready;
         wready  <= next_wready;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         arready <= next_arready;
         rvalid  <= next_rvalid;
         rdata   <= next_rdata;
         rresp   <= next_rresp;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_go(lbx_pkg::lbx_op_e o);
      go && c.op == o;
   endsequence

   AST_OR_WB: assert property (s_go(lbx_pkg::OP_DISJUNCT_REGS) |=> // RQ1
      regs[$past(c.rd)] == ($past(a) | $past(b)) && !flags[lbx_pkg::F_V])
      else $error("or result or flags wrong");
   AST_CLR_MASK: assert property (s_go(lbx_pkg::OP_CLEAR_MASK_BITS) |=> // RQ2
      regs[$past(c.rd)] == ($past(a) & ~$past(imm)))
      else $error("mask clear result wrong");
   AST_INVERT: assert property (s_go(lbx_pkg::OP_INVERT_ALL_BITS) |=> // RQ3
      flags[lbx_pkg::F_C] && regs[$past(c.rd)] == ~$past(a))
      else $error("complement wrong");
   AST_CHECK: assert property (s_go(lbx_pkg::OP_ZERO_SIGN_CHECK) |=> // RQ4
      flags[lbx_pkg::F_N] == $past(a[7]) && regs[$past(c.rd)] == $past(a))
      else $error("sign check wrong");
   AST_ZERO: assert property (s_go(lbx_pkg::OP_ZERO_REGISTER) |=> // RQ5
      regs[$past(c.rd)] == 8'h00 && flags[lbx_pkg::F_Z])
      else $error("clear register wrong");
   AST_DEC: assert property (s_go(lbx_pkg::OP_SUBTRACT_ONE) |=> // RQ6
      $stable(flags[lbx_pkg::F_C]) && last_cyc == 2'h1 &&
      flags[lbx_pkg::F_V] == ($past(a) == 8'h80))
      else $error("decrement flags wrong");
   AST_JUMP_LEN: assert property (s_go(lbx_pkg::OP_REL_JUMP) ##1 ce // RQ7
      |=> !busy && last_cyc == 2'h2)
      else $error("relative jump length wrong");
   AST_REL_SUBROUTINE_CALL: assert property (s_go(lbx_pkg::OP_REL_SUBROUTINE_CALL) // RQ7
      |=> pc == $past(pc) + 16'h0001 + $past(rel12) && $stable(flags) &&
      busy && last_cyc == 2'h3)
      else $error("relative call wrong");
   AST_PJUMP: assert property (s_go(lbx_pkg::OP_POINTER_JUMP) |=> // RQ8
      pc == $past(zptr) && last_cyc == 2'h2 && $stable(flags))
      else $error("pointer jump wrong");
   AST_PCALL: assert property (s_go(lbx_pkg::OP_POINTER_CALL) |=> // RQ9
      pc == $past(zptr) && last_cyc == 2'h3 && link == $past(pc) + 16'h0001)
      else $error("pointer call wrong");
   AST_EQ_SKIP: assert property (s_go(lbx_pkg::OP_EQUAL_SKIP) ##0 // RQ10
      (a == b && c.two_word) |=> pc == $past(pc) + 16'h0003 &&
      last_cyc == 2'h3)
      else $error("equal skip wrong");
   AST_CPI: assert property (s_go(lbx_pkg::OP_IMM_COMPARE) |=> // RQ11
      flags[lbx_pkg::F_C] == ($past(a) < $past(imm)) &&
      regs[$past(c.rd)] == $past(a))
      else $error("compare wrong");
   AST_BR_MISS: assert property (s_go(lbx_pkg::OP_BRANCH_CARRY_HIGH) ##0 // RQ15
      !flags[lbx_pkg::F_C] |=> pc == $past(pc) + 16'h0001 &&
      last_cyc == 2'h1)
      else $error("untaken branch wrong");

endmodule
`default_nettype wire

// ---- tb/lbx_exec_tb_top.sv ----
// self-checking bench for the logic and branch execution unit
`timescale 1ns/10ps
`default_nettype none
module lbx_exec_tb_top;
   // ------------------------------
   // signals and model state
   // ------------------------------
   logic              aclk;
   logic              aresetn;
   logic              ce;
   logic [7:0]        awaddr;
   logic              awvalid;
   logic              awready;
   logic [31:0]       wdata;
   logic [3:0]        wstrb;
   logic              wvalid;
   logic              wready;
   logic [1:0]        bresp;
   logic              bvalid;
   logic              bready;
   logic [7:0]        araddr;
   logic              arvalid;
   logic              arready;
   logic [31:0]       rdata;
   logic [1:0]        rresp;
   logic              rvalid;
   logic              rready;
   logic [15:0]       lf;
   logic [7:0]        m_fl;
   logic [7:0]        m_res;
   logic [15:0]       m_pc;
   logic [15:0]       m_ptr;
   logic [15:0]       m_link;
   logic [1:0]        m_cyc;
   lbx_pkg::lbx_cmd_s c;
   int                err_total;
   int                checks;
   int                i;

   // ce tied high: clock-enable stalls are not exercised, by this bench or by the design's own checks
   lbx_exec uut (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
   );

   always #2.5 aclk = ~aclk;

   // ------------------------------
   // checking, bus and model tasks
   // ------------------------------
   task automatic stop_test();
      if (err_total == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic no_answer();
      err_total++;
      $display("CHECK FAILED at %0t: bus wait ran out", $time);
      stop_test();
   endtask

   function automatic logic [15:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf;
   endfunction

   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
      int n;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (n == 100) no_answer();
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
      int n;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (n == 100) no_answer();
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      axr(a, d, r);
      chk(d & m, e);
      chk({30'h0, r}, {30'h0, er});
   endtask

   function automatic void predict(lbx_pkg::lbx_cmd_s c, logic [7:0] a,
                                   logic [7:0] b, logic [7:0] io);
      logic [8:0]  df;
      logic        hit;
      logic        tk;
      logic [15:0] nx;
      m_res = a;
      hit   = 1'b0;
      tk    = 1'b0;
      nx    = m_pc + 16'h0001;
      df    = {1'b0, a} - {1'b0, c.k[7:0]};
      m_cyc = lbx_pkg::CYC_ONE;
      case (c.op)
         lbx_pkg::OP_DISJUNCT_REGS: m_res = a | b;
         lbx_pkg::OP_DISJUNCT_IMM, lbx_pkg::OP_SET_MASK_BITS:
            m_res = a | c.k[7:0];
         lbx_pkg::OP_XDISJUNCT_REGS: m_res = a ^ b;
         lbx_pkg::OP_INVERT_ALL_BITS: m_res = 8'hff - a;
         lbx_pkg::OP_CLEAR_MASK_BITS: m_res = a & (8'hff - c.k[7:0]);
         lbx_pkg::OP_ZERO_SIGN_CHECK: m_res = a & a;
         lbx_pkg::OP_ZERO_REGISTER: m_res = a ^ a;
         lbx_pkg::OP_SUBTRACT_ONE: m_res = a - 8'h01;
         lbx_pkg::OP_REL_JUMP, lbx_pkg::OP_REL_SUBROUTINE_CALL:
            nx = nx + {{4{c.k[11]}}, c.k};
         lbx_pkg::OP_POINTER_JUMP, lbx_pkg::OP_POINTER_CALL: nx = m_ptr;
         lbx_pkg::OP_EQUAL_SKIP: hit = (a == b);
         lbx_pkg::OP_SKIP_REG_BIT_LOW: hit = !a[c.k[2:0]];
         lbx_pkg::OP_SKIP_REG_BIT_HIGH: hit = a[c.k[2:0]];
         lbx_pkg::OP_SKIP_IO_BIT_LOW: hit = !io[c.k[2:0]];
         lbx_pkg::OP_SKIP_IO_BIT_HIGH: hit = io[c.k[2:0]];
         lbx_pkg::OP_BRANCH_FLAG_HIGH: tk = m_fl[c.rr[2:0]];
         lbx_pkg::OP_BRANCH_FLAG_LOW: tk = !m_fl[c.rr[2:0]];
         lbx_pkg::OP_BRANCH_CARRY_HIGH: tk = m_fl[lbx_pkg::F_C];
         lbx_pkg::OP_BRANCH_CARRY_LOW: tk = !m_fl[lbx_pkg::F_C];
         default: ;
      endcase
      if (c.op == lbx_pkg::OP_REL_SUBROUTINE_CALL ||
          c.op == lbx_pkg::OP_POINTER_CALL) begin
         m_cyc  = lbx_pkg::CYC_THREE;
         m_link = m_pc + 16'h0001;
      end
      if (c.op == lbx_pkg::OP_REL_JUMP || c.op == lbx_pkg::OP_POINTER_JUMP)
         m_cyc = lbx_pkg::CYC_TWO;
      if (hit) begin
         nx    = m_pc + (c.two_word ? 16'h0003 : 16'h0002);
         m_cyc = c.two_word ? lbx_pkg::CYC_THREE : lbx_pkg::CYC_TWO;
      end
      if (tk) begin
         nx    = nx + {{9{c.k[6]}}, c.k[6:0]};
         m_cyc = lbx_pkg::CYC_TWO;
      end
      if (c.op <= lbx_pkg::OP_SUBTRACT_ONE) begin
         m_fl[lbx_pkg::F_Z] = (m_res == 8'h00);
         m_fl[lbx_pkg::F_N] = m_res[7];
         m_fl[lbx_pkg::F_V] = (c.op == lbx_pkg::OP_SUBTRACT_ONE) && a == 8'h80;
         if (c.op == lbx_pkg::OP_INVERT_ALL_BITS) m_fl[lbx_pkg::F_C] = 1'b1;
      end
      if (c.op == lbx_pkg::OP_IMM_COMPARE) begin
         m_fl[lbx_pkg::F_Z] = (df[7:0] == 8'h00);
         m_fl[lbx_pkg::F_N] = df[7];
         m_fl[lbx_pkg::F_C] = df[8];
         m_fl[lbx_pkg::F_H] = (a[3:0] < c.k[3:0]);
         m_fl[lbx_pkg::F_V] = (a[7] != c.k[7]) && (df[7] != a[7]);
      end
      m_pc = nx;
   endfunction

   // loads operands, runs one command and compares flags, cycle count, result register, pc and link
   task automatic run(input lbx_pkg::lbx_cmd_s c, input logic [7:0] vd,
                      input logic [7:0] vr, input logic [15:0] pcv);
      logic [31:0] d;
      logic [1:0]  r;
      logic [7:0]  io;
      int          n;
      io    = 8'(rnd());
      m_ptr = rnd();
      // the bit skips name one register, so both fields point at it
      if (c.op == lbx_pkg::OP_SKIP_REG_BIT_LOW ||
          c.op == lbx_pkg::OP_SKIP_REG_BIT_HIGH) c.rr = c.rd;
      axw(lbx_pkg::A_RSEL, {27'h0, c.rr}, lbx_pkg::RESP_OKAY);
      axw(lbx_pkg::A_RDATA, {24'h0, vr}, lbx_pkg::RESP_OKAY);
      axw(lbx_pkg::A_RSEL, {27'h0, c.rd}, lbx_pkg::RESP_OKAY);
      axw(lbx_pkg::A_RDATA, {24'h0, vd}, lbx_pkg::RESP_OKAY);
      axw(lbx_pkg::A_PC, {16'h0, pcv}, lbx_pkg::RESP_OKAY);
      axw(lbx_pkg::A_PTR, {16'h0, m_ptr}, lbx_pkg::RESP_OKAY);
      axw(lbx_pkg::A_IOV, {24'h0, io}, lbx_pkg::RESP_OKAY);
      // status writes are ignored, so flags must survive this
      axw(lbx_pkg::A_STAT, 32'hffffffff, lbx_pkg::RESP_OKAY);
      m_pc = pcv;
      predict(c, vd, (c.rd == c.rr) ? vd : vr, io);
      axw(lbx_pkg::A_CMD, {4'h0, c}, lbx_pkg::RESP_OKAY);
      for (n = 0; n < 20; n++) begin
         axr(lbx_pkg::A_STAT, d, r);
         if (d[8] === 1'b0) break;
      end
      if (n == 20) no_answer();
      chk({24'h0, d[7:0]}, {24'h0, m_fl});
      chk({30'h0, d[10:9]}, {30'h0, m_cyc});
      rdchk(lbx_pkg::A_RDATA, 32'hff, {24'h0, m_res}, 2'h0);
      rdchk(lbx_pkg::A_PC, 32'hffff, {16'h0, m_pc}, 2'h0);
      rdchk(lbx_pkg::A_LINK, 32'hffff, {16'h0, m_link}, 2'h0);
   endtask

   task automatic go(input lbx_pkg::lbx_cmd_s c);
      logic [15:0] a;
      a = rnd();
      run(c, a[7:0], a[15:8], rnd());
   endtask

   function automatic lbx_pkg::lbx_cmd_s rand_cmd();
      logic [31:0] x;
      x = {rnd(), rnd()};
      return lbx_pkg::lbx_cmd_s'(x[27:0]);
   endfunction

   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      aclk = 1'b0; aresetn = 1'b0; ce = 1'b1; wstrb = 4'hf;
      awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wvalid = 1'b0;
      bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0;
      lf = 16'h001e; err_total = 0; checks = 0;
      m_fl = lbx_pkg::FLAGS_RST; m_link = lbx_pkg::PC_RST;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rdchk(lbx_pkg::A_PC, 32'hffff, 32'h0, lbx_pkg::RESP_OKAY);
      rdchk(lbx_pkg::A_STAT, 32'h7ff, 32'h0, lbx_pkg::RESP_OKAY);
      rdchk(lbx_pkg::A_RDATA, 32'hff, 32'h0, lbx_pkg::RESP_OKAY);
      // unmapped and unaligned places are refused
      axw(8'h20, 32'h0000ffff, lbx_pkg::RESP_ERR);
      axw(8'h02, 32'h0000ffff, lbx_pkg::RESP_ERR);
      rdchk(8'h24, 32'hffffffff, 32'h0, lbx_pkg::RESP_ERR);
      rdchk(lbx_pkg::A_PC, 32'hffff, 32'h0, lbx_pkg::RESP_OKAY);
      // every code once, reserved ones included
      for (i = 0; i < 32; i++) begin
         c = rand_cmd();
         c.op = lbx_pkg::lbx_op_e'(i[4:0]);
         go(c);
      end
      // corners: self-xor, decrement wrap, far jumps, equal skip, borrow
      c = rand_cmd(); c.op = lbx_pkg::OP_XDISJUNCT_REGS; c.rr = c.rd;
      run(c, 8'ha5, 8'h00, 16'h0010);
      c.op = lbx_pkg::OP_SUBTRACT_ONE;
      run(c, 8'h80, 8'h00, 16'h0010);
      run(c, 8'h00, 8'h00, 16'hffff);
      c.op = lbx_pkg::OP_REL_SUBROUTINE_CALL; c.k = 12'h800;
      run(c, 8'h00, 8'h00, 16'h0005);
      c.op = lbx_pkg::OP_REL_JUMP; c.k = 12'h7ff;
      run(c, 8'h00, 8'h00, 16'hfffe);
      c.op = lbx_pkg::OP_EQUAL_SKIP; c.rr = c.rd + 5'h01; c.two_word = 1'b1;
      run(c, 8'h3c, 8'h3c, 16'h0100);
      c.op = lbx_pkg::OP_IMM_COMPARE; c.k = 12'h001;
      run(c, 8'h00, 8'h00, 16'h0200);
      c.op = lbx_pkg::OP_BRANCH_CARRY_HIGH; c.k = 12'h040;
      run(c, 8'h00, 8'h00, 16'h0020);
      for (i = 0; i < 150; i++) go(rand_cmd());
      stop_test();
   end
endmodule
`default_nettype wire
